/* src/csw_defs.svh */
// Constants for the clock-speed and SRAM wait configuration block.
// Assumes inclusion by bare name from every file that needs offsets or counts.
`ifndef CSW_DEFS_SVH
`define CSW_DEFS_SVH

// =============================================================
// Register word indices (byte address is four times the index).
`define CSW_CFG_IDX 6'h00
`define CSW_STAT_IDX 6'h01

// =============================================================
// Field positions in the configuration byte.
`define CSW_FAST_BIT 7
`define CSW_RSV_BIT 6
`define CSW_WAIT_HI 5
`define CSW_WAIT_LO 4
`define CSW_LONG_BIT 3

// =============================================================
// Reset value and writable-bit mask of the configuration byte.
`define CSW_CFG_RST 8'hB0
`define CSW_CFG_WMASK 8'hB8

// =============================================================
// Timing counts in input-clock periods.
`define CSW_LONG_FAST 8'hC0
`define CSW_LONG_SLOW 8'h60
`define CSW_BASE_CYC 8'h02
`define CSW_WS_CYC 8'h02

`endif

/* src/csw_pkg.sv */
// Types and shared arithmetic for the clock-speed and SRAM wait block.
// Assumes the constants header is on the include path.
`include "csw_defs.svh"

package csw_pkg;

  // =============================================================
  // Sequencer states and access targets.
  typedef enum logic [1:0] {ST_IDLE, ST_LONG, ST_ACCESS, ST_DONE} csw_state_t;
  typedef enum logic [1:0] {TGT_SRAM, TGT_FLASH, TGT_XCVR, TGT_OTHER} csw_tgt_t;

  // Length of one host long-wait period for the given clock flag.
  function automatic logic [7:0] csw_long_len(input logic fast);
    return fast ? `CSW_LONG_FAST : `CSW_LONG_SLOW;
  endfunction

  // Length of the access phase; only SRAM takes the programmed wait states.
  function automatic logic [7:0] csw_acc_len(input logic [1:0] ws, input logic is_sram);
    logic [7:0] ext;
    ext = is_sram ? {6'h00, ws} : 8'h00;
    return 8'(`CSW_BASE_CYC + ext * `CSW_WS_CYC);
  endfunction

  // Targets that suffer the host long wait.
  function automatic logic csw_long_tgt(input logic [1:0] t);
    return t != TGT_OTHER;
  endfunction

endpackage

/* src/csw_ctl_if.sv */
// Internal carrier between the top, the clock divider and the wait timer.
// Assumes one instance inside the top, clocked by the core clock.
interface csw_ctl_if (
  input wire logic clk,  // Core clock.
  input wire logic rst_n // Synchronous reset, active low.
);
  logic fast_clock_flag;
  logic attach_clk_en;
  logic tmr_load;
  logic [7:0] tmr_value;
  logic tmr_done;

  modport div (input clk, rst_n, fast_clock_flag, output attach_clk_en);
  modport tmr (input clk, rst_n, tmr_load, tmr_value, output tmr_done);
  modport top (output fast_clock_flag, tmr_load, tmr_value, input attach_clk_en, tmr_done);
endinterface

/* src/csw_clkdiv.sv */
// Enable generator for the transceiver attachment section.
// Assumes the flag comes from a register on the same clock.
module csw_clkdiv import csw_pkg::*; (
  csw_ctl_if.div ctl // Flag in, enable out.
);
  logic phase_reg;
  logic phase_next;
  logic en_reg;
  logic en_next;

  // =============================================================
  // Divide by two only while the fast flag is set.
  always_comb begin
    phase_next = ctl.fast_clock_flag ? ~phase_reg : 1'b0;
    en_next = ~ctl.fast_clock_flag | phase_next;
  end

  // Registers only. The phase starts high so that, with the flag set, the
  // enable after the high reset value is low and never stands two cycles.
  always_ff @(posedge ctl.clk) begin
    if (!ctl.rst_n) begin
      phase_reg <= 1'b1;
      en_reg <= 1'b1;
    end else begin
      phase_reg <= phase_next;
      en_reg <= en_next;
    end
  end

  assign ctl.attach_clk_en = en_reg;

  a_attach_half_rate: assert property (@(posedge ctl.clk) disable iff (!ctl.rst_n)
    ($past(ctl.fast_clock_flag) && ctl.fast_clock_flag && ctl.attach_clk_en)
      |=> !ctl.attach_clk_en)
    else $error("enable not halved while fast flag set");
  a_attach_full_rate: assert property (@(posedge ctl.clk) disable iff (!ctl.rst_n)
    !ctl.fast_clock_flag |=> ctl.attach_clk_en)
    else $error("enable missing while fast flag clear");

endmodule // csw_clkdiv

/* src/csw_wait_timer.sv */
// Loadable down counter that times long waits and access phases.
// Assumes a load value of at least one; done marks the final counted cycle.
module csw_wait_timer import csw_pkg::*; (
  csw_ctl_if.tmr ctl // Load and value in, done out.
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;

  // =============================================================
  // Count down to zero and rest there; a load restarts the period.
  always_comb begin
    if (ctl.tmr_load) begin
      cnt_next = ctl.tmr_value;
    end else if (cnt_reg != 8'h00) begin
      cnt_next = cnt_reg - 8'h01;
    end else begin
      cnt_next = cnt_reg;
    end
  end

  always_ff @(posedge ctl.clk) begin
    if (!ctl.rst_n) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Done does not look at load, so the sequencer may reload on done.
  assign ctl.tmr_done = (cnt_reg == 8'h01);

  a_tmr_load_value: assert property (@(posedge ctl.clk) disable iff (!ctl.rst_n)
    ctl.tmr_load |=> cnt_reg == $past(ctl.tmr_value))
    else $error("timer did not take load value");

endmodule // csw_wait_timer

/* src/csw_top.sv */
// Clock-speed and SRAM wait configuration with its access sequencer.
// Assumes a classic Wishbone master and requesters on the same clock.
//
// Chosen here: register access over Wishbone and the register addresses.
`include "csw_defs.svh"

module csw_top import csw_pkg::*; (
  input wire logic core_clk, // Input clock, 20 MHz.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [7:0] wb_adr_i, // Wishbone byte address.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  input wire logic core_req, // Embedded core access request.
  input wire logic [1:0] core_tgt, // Embedded core access target.
  output logic core_ack, // Embedded core access done.
  input wire logic host_req, // Host system access request.
  input wire logic [1:0] host_tgt, // Host system access target.
  output logic host_ack, // Host system access done.
  output logic attach_clk_en, // Transceiver section clock enable.
  output logic fast_clock_flag, // Current fast clock flag.
  output logic [1:0] sram_wait_count // Current SRAM wait states.
);

  // =============================================================
  // Internal carrier and the two helper blocks.
  csw_ctl_if ctl (
    .clk(core_clk),
    .rst_n(rst_n)
  );

  csw_clkdiv u_div (
    .ctl(ctl)
  );

  csw_wait_timer u_tmr (
    .ctl(ctl)
  );

  // =============================================================
  // Register bus state.
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdat_reg;
  logic [31:0] rdat_next;
  logic [5:0] idx;
  logic wr_commit;
  logic host_long_wait_a;
  logic [7:0] status;

  // =============================================================
  // Sequencer state.
  csw_state_t state_reg;
  csw_state_t state_next;
  logic owner_host_reg;
  logic owner_host_next;
  logic [1:0] tgt_reg;
  logic [1:0] tgt_next;
  logic load;
  logic [7:0] load_value;
  logic fast_sel_reg;
  logic fast_sel_next;
  logic [1:0] ws_sel_reg;
  logic [1:0] ws_sel_next;
  logic [8:0] dur_reg;
  logic [8:0] dur_next;

  assign idx = wb_adr_i[7:2];
  assign fast_clock_flag = cfg_reg[`CSW_FAST_BIT];
  assign sram_wait_count = cfg_reg[`CSW_WAIT_HI:`CSW_WAIT_LO];
  assign host_long_wait_a = cfg_reg[`CSW_LONG_BIT];

  // A write lands on the edge at which the master sees ack.
  assign wr_commit = ack_reg & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];

  // Status byte: busy, owner, long wait and access phase.
  assign status = {4'h0, state_reg == ST_ACCESS, state_reg == ST_LONG,
                   owner_host_reg, state_reg != ST_IDLE};

  // =============================================================
  // Bus next-state: one-cycle ack, read data latched with it.
  always_comb begin
    ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
    rdat_next = rdat_reg;
    cfg_next = cfg_reg;
    if (wb_cyc_i && wb_stb_i && !ack_reg) begin
      case (idx)
        `CSW_CFG_IDX: rdat_next = {24'h000000, cfg_reg};
        `CSW_STAT_IDX: rdat_next = {24'h000000, status};
        default: rdat_next = 32'h00000000;
      endcase
    end
    // The reserved bit and the bits outside this block are never stored.
    if (wr_commit && idx == `CSW_CFG_IDX) begin
      cfg_next = wb_dat_i[7:0] & `CSW_CFG_WMASK;
    end
  end

  // Bus registers; the fast flag and the wait field come up set.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg_reg <= `CSW_CFG_RST;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h00000000;
    end else begin
      cfg_reg <= cfg_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // =============================================================
  // Sequencer next-state. The core wins a tie; the settings are
  // captured at the start, so a write mid-access cannot stretch it.
  always_comb begin
    state_next = state_reg;
    owner_host_next = owner_host_reg;
    tgt_next = tgt_reg;
    fast_sel_next = fast_sel_reg;
    ws_sel_next = ws_sel_reg;
    load = 1'b0;
    load_value = 8'h00;
    case (state_reg)
      ST_IDLE: begin
        if (core_req) begin
          owner_host_next = 1'b0;
          tgt_next = core_tgt;
          ws_sel_next = sram_wait_count;
          load = 1'b1;
          load_value = csw_acc_len(sram_wait_count, core_tgt == TGT_SRAM);
          state_next = ST_ACCESS;
        end else if (host_req) begin
          owner_host_next = 1'b1;
          tgt_next = host_tgt;
          ws_sel_next = sram_wait_count;
          fast_sel_next = fast_clock_flag;
          load = 1'b1;
          if (host_long_wait_a && csw_long_tgt(host_tgt)) begin
            load_value = csw_long_len(fast_clock_flag);
            state_next = ST_LONG;
          end else begin
            load_value = csw_acc_len(sram_wait_count, host_tgt == TGT_SRAM);
            state_next = ST_ACCESS;
          end
        end
      end
      ST_LONG: begin
        if (ctl.tmr_done) begin
          load = 1'b1;
          load_value = csw_acc_len(ws_sel_reg, tgt_reg == TGT_SRAM);
          state_next = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (ctl.tmr_done) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      owner_host_reg <= 1'b0;
      tgt_reg <= 2'h0;
      fast_sel_reg <= 1'b1;
      ws_sel_reg <= 2'h3;
    end else begin
      state_reg <= state_next;
      owner_host_reg <= owner_host_next;
      tgt_reg <= tgt_next;
      fast_sel_reg <= fast_sel_next;
      ws_sel_reg <= ws_sel_next;
    end
  end

  assign ctl.fast_clock_flag = fast_clock_flag;
  assign ctl.tmr_load = load;
  assign ctl.tmr_value = load_value;
  assign attach_clk_en = ctl.attach_clk_en;

  // Acks are one-cycle pulses from the done state.
  assign core_ack = (state_reg == ST_DONE) & ~owner_host_reg;
  assign host_ack = (state_reg == ST_DONE) & owner_host_reg;

  // =============================================================
  // Cycles spent in the current state, read only by the checks below.
  always_comb begin
    if (state_next != state_reg) begin
      dur_next = 9'h001;
    end else if (dur_reg != 9'h1FF) begin
      dur_next = dur_reg + 9'h001;
    end else begin
      dur_next = dur_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dur_reg <= 9'h001;
    end else begin
      dur_reg <= dur_next;
    end
  end

  // =============================================================
  // Checks.
  a_long_wait_len: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_reg == ST_LONG && state_next == ST_ACCESS)
      |-> dur_reg == (fast_sel_reg ? 9'h0C0 : 9'h060))
    else $error("long wait length wrong for clock flag");

  a_sram_wait_len: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_reg == ST_ACCESS && state_next == ST_DONE && tgt_reg == TGT_SRAM)
      |-> dur_reg == 9'h002 + {6'h00, ws_sel_reg, 1'b0})
    else $error("SRAM access length wrong for wait count");

  a_other_access_len: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_reg == ST_ACCESS && state_next == ST_DONE && tgt_reg != TGT_SRAM)
      |-> dur_reg == 9'h002)
    else $error("non-SRAM access took wait states");

  a_long_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_reg == ST_IDLE && !core_req && host_req && host_long_wait_a
      && host_tgt != TGT_OTHER) |=> state_reg == ST_LONG)
    else $error("host long wait not started");

  a_long_host_only: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_reg == ST_LONG) |-> (owner_host_reg && tgt_reg != TGT_OTHER))
    else $error("long wait applied to wrong access");

  a_rsv_reads_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wb_ack_o && !wb_we_i && idx == `CSW_CFG_IDX) |-> wb_dat_o[`CSW_RSV_BIT] == 1'b0)
    else $error("reserved bit read as one");

  a_ack_once: assert property (@(posedge core_clk) disable iff (!rst_n)
    (core_ack || host_ack) |=> !(core_ack || host_ack) ##1 !(core_ack || host_ack))
    else $error("access ack longer than one cycle");

  // Bus handshake: every request gets exactly one single-cycle ack.
  a_bus_ack_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("bus request not acknowledged");

  a_bus_ack_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");

  // Only the writable bits of a committed write reach the register.
  a_cfg_write_mask: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_commit && idx == `CSW_CFG_IDX)
      |=> cfg_reg == ($past(wb_dat_i[7:0]) & `CSW_CFG_WMASK))
    else $error("config write stored wrong bits");

  a_cfg_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(wr_commit && idx == `CSW_CFG_IDX) |=> $stable(cfg_reg))
    else $error("config changed without a write");

  // Settings are captured when an access is taken, and the core wins a tie.
  a_ws_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_reg == ST_IDLE && (core_req || host_req))
      |=> ws_sel_reg == $past(sram_wait_count))
    else $error("wait count not captured at access start");

  a_core_priority: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_reg == ST_IDLE && core_req) |=> (state_reg == ST_ACCESS && !owner_host_reg))
    else $error("core request not taken first");

  a_fast_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_reg == ST_IDLE && !core_req && host_req)
      |=> fast_sel_reg == $past(fast_clock_flag))
    else $error("clock flag not captured at host access");

  c_host_long_fast: cover property (@(posedge core_clk) disable iff (!rst_n)
    state_reg == ST_LONG && fast_sel_reg && state_next == ST_ACCESS);
  c_sram_three_ws: cover property (@(posedge core_clk) disable iff (!rst_n)
    state_reg == ST_ACCESS && tgt_reg == TGT_SRAM && ws_sel_reg == 2'h3 && core_ack == 1'b0
      && state_next == ST_DONE);
  c_cfg_write: cover property (@(posedge core_clk) disable iff (!rst_n)
    wr_commit && idx == `CSW_CFG_IDX);
  c_host_long_slow: cover property (@(posedge core_clk) disable iff (!rst_n)
    state_reg == ST_LONG && !fast_sel_reg && state_next == ST_ACCESS);

endmodule // csw_top

/* sim/csw_req_model.sv */
// Requester model for the embedded core or the host side of the access port.
// Assumes the block answers each request with a one-cycle ack on the core clock.
module csw_req_model (
  input wire logic clk, // Core clock.
  input wire logic ack, // Access done from the block.
  output logic req, // Access request.
  output logic [1:0] tgt // Access target.
);
  timeunit 1ns;
  timeprecision 1ns;

  // =============================================================
  // Idle state; the target is not left showing a stale value.
  initial begin
    req = 1'b0;
    tgt = 2'h3;
  end

  // One access: hold req and target until ack is sampled, count the edges.
  task automatic access(input logic [1:0] t, output int n);
    n = 0;
    @(posedge clk);
    req <= 1'b1;
    tgt <= t;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 400);
    req <= 1'b0;
    tgt <= ~t;
  endtask
endmodule // csw_req_model

/* sim/clock_speed_sram_wait_cfg_tb.sv */
// Self-checking bench for the clock-speed and SRAM wait block.
// Assumes csw_top, its package and a requester model for each access side.
module clock_speed_sram_wait_cfg_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic ack;
  logic core_req, core_ack, host_req, host_ack, att, flag;
  logic [1:0] core_tgt, host_tgt, ws;
  logic [31:0] seed = 32'h0000FDB8;
  logic [31:0] q;
  int errors = 0;
  int checks = 0;
  int cfg_m;
  int n;

  // =============================================================
  // Clock, design and requester models.
  always #25 core_clk = ~core_clk;
  csw_top dut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .core_req(core_req), .core_tgt(core_tgt), .core_ack(core_ack),
    .host_req(host_req), .host_tgt(host_tgt), .host_ack(host_ack), .attach_clk_en(att),
    .fast_clock_flag(flag), .sram_wait_count(ws));
  csw_req_model core_m (.clk(core_clk), .ack(core_ack), .req(core_req), .tgt(core_tgt));
  csw_req_model host_m (.clk(core_clk), .ack(host_ack), .req(host_req), .tgt(host_tgt));

  // =============================================================
  // Helpers: random source, comparison, bus cycles, expected timing.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Classic single cycle; everything is held until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do begin
      @(posedge core_clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk(32'(ack), 32'h1, "bus ack missing");
  endtask

  // Only bits 7, 5:4 and 3 are kept; the rest read back as zero.
  task automatic wr(input logic [31:0] d);
    wb(1'b1, 8'h00, d);
    cfg_m = int'(d & 32'h000000B8);
  endtask

  // Edges from raising req to sampling ack: long wait, access phase, done.
  function automatic int exp_len(input bit host, input int t);
    int l;
    l = 0;
    if (host && cfg_m[3] && t != 3) l = cfg_m[7] ? 192 : 96;
    return l + 2 + (t == 0 ? 2 * cfg_m[5:4] : 0) + 2;
  endfunction

  // The enable alternates while the flag is set and stays high otherwise.
  task automatic attach_chk();
    logic p;
    repeat (3) @(posedge core_clk);
    p = att;
    repeat (4) begin
      @(posedge core_clk);
      chk(32'(att), cfg_m[7] ? {31'h0, ~p} : 32'h1, "attach enable");
      p = att;
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // =============================================================
  // Hang guard, sized well beyond the longest run of accesses.
  initial begin
    repeat (60000) @(posedge core_clk);
    errors++;
    $display("ERROR t=%0t watchdog expired", $time);
    final_report();
  end

  // =============================================================
  // Main sequence.
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    cfg_m = 32'h000000B0;
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'(cfg_m), "reset config");
    chk(32'({flag, ws}), 32'h7, "reset outputs");
    wb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h0, "idle status");
    wb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h0, "unmapped read");
    attach_chk();
    $display("test reset done");
    // Random settings; bit 6 is always written as zero.
    repeat (6) begin
      wr(xs() & 32'hFFFFFFBF);
      wb(1'b0, 8'h00, 32'h0);
      chk(q, 32'(cfg_m), "config readback");
      chk(32'({flag, ws}), 32'({cfg_m[7], cfg_m[5:4]}), "field outputs");
      attach_chk();
    end
    $display("test config done");
    // Every flag, long-wait and wait-count setting against every target.
    for (int f = 0; f < 2; f++) begin
      for (int lw = 0; lw < 2; lw++) begin
        for (int w = 0; w < 4; w++) begin
          wr(32'((f << 7) | (w << 4) | (lw << 3)));
          for (int t = 0; t < 4; t++) begin
            core_m.access(2'(t), n);
            chk(32'(n), 32'(exp_len(1'b0, t)), "core access length");
            host_m.access(2'(t), n);
            chk(32'(n), 32'(exp_len(1'b1, t)), "host access length");
          end
        end
      end
    end
    // Status read while a host flash access sits in its long wait.
    wr(32'h00000088);
    fork
      host_m.access(2'h1, n);
      begin
        repeat (4) @(posedge core_clk);
        wb(1'b0, 8'h04, 32'h0);
        chk(q, 32'h7, "status in long wait");
      end
    join
    chk(32'(n), 32'(exp_len(1'b1, 1)), "host flash length");
    $display("test access done");
    final_report();
  end
endmodule // clock_speed_sram_wait_cfg_tb
